/* File: bench/pbs_host_bus.sv */
// Far-side data wire model: the controller's write drive plus the device.
// Assumes the host never drives while the device read path is enabled.
`timescale 1ns/1ps

module pbs_host_bus (
	input  wire logic        clock_i,
	input  wire logic        host_en_i,
	input  wire logic [31:0] host_dq_i,
	input  wire logic        dq_oe_i,
	input  wire logic [31:0] dq_i,
	output logic [31:0]      bus_o
);
	// Known start value keeps the floating wire free of unknowns
	logic [31:0] last_reg = 32'h0000_0000;

	always_comb begin
		if (host_en_i && dq_oe_i)
			bus_o = 'x;
		else if (host_en_i)
			bus_o = host_dq_i;
		else if (dq_oe_i)
			bus_o = dq_i;
		else
			bus_o = ~last_reg;
	end

	// Floating wire must not look like the last driven word
	always_ff @(posedge clock_i) begin
		if (host_en_i || dq_oe_i)
			last_reg <= bus_o;
	end
endmodule

/* File: bench/tb_pipelined_burst_sram.sv */
// Self-checking bench of the burst SRAM: pin cycles with expected reads.
// Assumes pbs_pkg and pbs_sram compiled first.
`timescale 1ns/1ps

module tb_pipelined_burst_sram;
	import pbs_pkg::*;
	logic        clock_i, nrst_i, oe_n, host_en, strap, chk_on;
	logic [31:0] host_dq, bus, dq_o, w_d, p1_d, p2_d;
	logic        dq_oe_o, wr_ready_o, w_v, w_oe, p1_v, p1_oe, p2_v, p2_oe;
	logic [31:0] mem [logic [15:0]];
	logic [15:0] a;
	logic [1:0]  cnt;
	pbs_in_s     pin, q;
	int          n_errors, n_checks, cyc;

	pbs_sram #(.DEPTH(4)) dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
		.addr_i(pin.addr), .processor_addr_strobe_n_i(pin.proc_strobe_n),
		.controller_addr_strobe_n_i(pin.ctrl_strobe_n),
		.burst_step_n_i(pin.burst_step_n),
		.chip_select_primary_n_i(pin.cs_primary_n),
		.chip_select_second_i(pin.cs_second),
		.chip_select_third_n_i(pin.cs_third_n),
		.byte_lane_write_sel_n_i(pin.lane_sel_n),
		.byte_write_qualifier_n_i(pin.qualifier_n),
		.all_bytes_write_n_i(pin.all_bytes_n), .burst_order_i(pin.linear_n),
		.out_enable_n_i(oe_n), .dq_i(bus), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.wr_ready_o(wr_ready_o));

	pbs_host_bus host_u (.clock_i(clock_i), .host_en_i(host_en),
		.host_dq_i(host_dq), .dq_oe_i(dq_oe_o), .dq_i(dq_o), .bus_o(bus));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic pbs_in_s mk(input logic pn, input logic cn,
		input logic [15:0] ad, input logic sn, input logic [2:0] cs);
		pbs_in_s r;
		r = IN_RST;
		r.proc_strobe_n = pn;
		r.ctrl_strobe_n = cn;
		r.addr = ad;
		r.burst_step_n = sn;
		{r.cs_primary_n, r.cs_second, r.cs_third_n} = cs;
		r.linear_n = strap;
		return r;
	endfunction

	// Expected read word and enable ride a two-stage pipe to the compare
	task put(input pbs_in_s s, input logic hd, input logic dv,
		input logic [31:0] de, input logic oe);
		@(posedge clock_i);
		pin <= s;
		host_en <= hd;
		host_dq <= s.wdata;
		w_v <= dv;
		w_d <= de;
		w_oe <= oe & ~oe_n;
	endtask

	task desel;
		put(mk(1, 0, 16'h0000, 1, 3'b110), 0, 0, 32'h0000_0000, 0);
	endtask

	task idle(input int n);
		repeat (n) put(mk(1, 1, 16'h0000, 1, 3'b101), 0, 0, 32'h0000_0000, 0);
	endtask

	initial begin
		clock_i = 0;
		forever #5 clock_i = ~clock_i;
	end

	always @(posedge clock_i) begin
		p1_v <= w_v;
		p1_oe <= w_oe;
		p1_d <= w_d;
		p2_v <= p1_v;
		p2_oe <= p1_oe;
		p2_d <= p1_d;
		cyc++;
		if (cyc > 1000) begin
			n_errors++;
			end_sim();
		end
	end

	always @(negedge clock_i) begin
		if (chk_on) begin
			check({31'h0, dq_oe_o}, {31'h0, p2_oe});
			if (p2_v)
				check(dq_o, p2_d);
			if (p2_v && p2_oe)
				check(bus, p2_d);
		end
	end

	initial begin
		nrst_i = 0;
		strap = 1;
		pin = IN_RST;
		{oe_n, host_en, host_dq, chk_on} = {1'b1, 1'b0, 32'h0000_0000, 1'b0};
		{w_v, w_oe, w_d, p1_v, p1_oe, p2_v, p2_oe} = '0;
		{n_errors, n_checks, cyc} = '0;
		repeat (10) @(posedge clock_i);
		check({31'h0, wr_ready_o}, 32'h0000_0001);
		check({31'h0, dq_oe_o}, 32'h0000_0000);
		check(dq_o, 32'h0000_0000);
		nrst_i <= 1;
		chk_on = 1;
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			q = mk(1, 0, 16'(16'h0040 + i), 1, 3'b010);
			q.all_bytes_n = 0;
			q.wdata = 32'h1111_1111 * (i + 1);
			put(q, 1, 0, 32'h0000_0000, 0);
			mem[q.addr] = q.wdata;
		end
		q = mk(1, 0, 16'h0041, 1, 3'b010);
		{q.lane_sel_n, q.qualifier_n, q.wdata} = {4'hA, 1'b0, 32'hABCD_EF01};
		put(q, 1, 0, 32'h0000_0000, 0);
		mem[16'h0041] = {mem[16'h0041][31:24], 8'hCD, mem[16'h0041][15:8], 8'h01};
		q = mk(1, 0, 16'h0042, 1, 3'b010);
		{q.lane_sel_n, q.qualifier_n, q.wdata} = {4'h0, 1'b1, 32'h5555_5555};
		put(q, 1, 0, 32'h0000_0000, 0);
		q = mk(0, 0, 16'h0043, 1, 3'b010);
		{q.all_bytes_n, q.wdata} = {1'b0, 32'h6666_6666};
		put(q, 1, 0, 32'h0000_0000, 0);
		desel();
		idle(6);
		check({31'h0, wr_ready_o}, 32'h0000_0001);
		$display("test writes done");
		oe_n <= 0;
		for (int m = 0; m < 2; m++) begin
			strap = m[0];
			desel();
			put(mk(m[0] ? 1'b0 : 1'b1, m[0], 16'h0041, 1, 3'b010),
				0, 1, mem[16'h0041], 0);
			cnt = 0;
			for (int k = 0; k < 4; k++) begin
				if (k != 1)
					cnt++;
				a = m ? {14'h0010, 2'h1 ^ cnt} : {14'h0010, 2'h1 + cnt};
				put(mk(1, 1, 16'hFFFF, k == 1, 3'b010), 0, 1, mem[a], 1);
			end
			desel();
			idle(2);
		end
		$display("test bursts done");
		for (int c = 0; c < 8; c++) begin
			if (c != 2) begin
				put(mk(1, 0, 16'h0042, 1, 3'b010), 0, 1, mem[16'h0042], 0);
				put(mk(0, 1, 16'h0043, 1, 3'b110), 0, 1, mem[16'h0042], 1);
				put(mk(1, 0, 16'h0043, 1, 3'(c)), 0, 0, 32'h0000_0000, 0);
			end
		end
		idle(2);
		$display("test selects done");
		chk_on = 0;
		put(mk(1, 0, 16'h0040, 1, 3'b010), 0, 0, 32'h0000_0000, 0);
		repeat (3) put(mk(1, 1, 16'hFFFF, 1, 3'b010), 0, 0, 32'h0000_0000, 0);
		// Output enable is moved between edges on purpose
		#2;
		oe_n = 1;
		#1;
		check({31'h0, dq_oe_o}, 32'h0000_0000);
		oe_n = 0;
		#1;
		check({31'h0, dq_oe_o}, 32'h0000_0001);
		check(bus, mem[16'h0040]);
		desel();
		idle(3);
		chk_on = 1;
		idle(2);
		$display("test output enable done");
		end_sim();
	end
endmodule

/* File: src/pbs_pkg.sv */
// Shared constants and carrier types of the pipelined burst SRAM.
// Assumes a single 100 MHz clock and no register bus.
package pbs_pkg;

	localparam int ADDR_W     = 16;
	localparam int DATA_W     = 32;
	localparam int LANES      = 4;
	localparam int WORDS      = 65536;
	localparam int FIFO_DEPTH = 4;

	localparam logic [1:0]  CNT_RST   = 2'h0;
	localparam logic [13:0] BASE_RST  = 14'h0000;
	localparam logic [31:0] DATA_RST  = 32'h0000_0000;
	localparam logic [3:0]  BE_ALL    = 4'hF;
	localparam logic [3:0]  BE_NONE   = 4'h0;
	localparam logic [1:0]  CNT_STEP  = 2'h1;

	// Everything sampled from the pins at one rising edge
	typedef struct packed {
		logic [15:0] addr;
		logic        proc_strobe_n;
		logic        ctrl_strobe_n;
		logic        burst_step_n;
		logic        cs_primary_n;
		logic        cs_second;
		logic        cs_third_n;
		logic [3:0]  lane_sel_n;
		logic        qualifier_n;
		logic        all_bytes_n;
		logic        linear_n;
		logic [31:0] wdata;
	} pbs_in_s;

	// Idle pins: no strobe, deselected, no write
	localparam pbs_in_s IN_RST = '{
		addr: 16'h0000, proc_strobe_n: 1'b1, ctrl_strobe_n: 1'b1,
		burst_step_n: 1'b1, cs_primary_n: 1'b1, cs_second: 1'b0,
		cs_third_n: 1'b1, lane_sel_n: 4'hF, qualifier_n: 1'b1,
		all_bytes_n: 1'b1, linear_n: 1'b1, wdata: 32'h0000_0000};

	// One pending write for the self-timed write path
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] data;
		logic [3:0]  be;
	} pbs_wr_s;

endpackage

/* File: src/pbs_sram.sv */
// Pipelined burst SRAM core with its write FIFO.
// Pins other than out_enable_n_i and the asynchronous reset nrst_i are taken as synchronous to clock_i; the data pin is split into
// input, output and enable, the wire is resolved outside.
`timescale 1ns/1ps

module pbs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	// DEPTH must be a power of two so the pointers wrap by themselves
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] buf_mem [DEPTH];
	logic [PW-1:0]    wp_reg;
	logic [PW-1:0]    wp_next;
	logic [PW-1:0]    rp_reg;
	logic [PW-1:0]    rp_next;
	logic [CW-1:0]    cnt_reg;
	logic [CW-1:0]    cnt_next;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_reg != CW'(DEPTH));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = buf_mem[rp_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always_comb begin
		wp_next  = wp_reg + PW'(push);
		rp_next  = rp_reg + PW'(pop);
		cnt_next = cnt_reg + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge clock_i) begin
		if (push) begin
			buf_mem[wp_reg] <= in_data_i;
		end
	end
endmodule

//Contract
//- Register every synchronous input at rising edge
//- Read data leaves through output registers
//- 64K by 32 array, one shared data bus
//- Load address on strobe with chip selected
//- Low address bits seed 2-bit burst counter
//- Step counter on edges with advance low
//- Burst order interleaved or linear by strap
//- Select needs primary low, second high, third low
//- Byte write: low selects, qualifier low
//- All-bytes write overrides byte selects
//- Writes finish internally, no extra pulse
//- Mask outputs first read after deselect
//- Output enable acts without a clock
//- Both strobes low: processor strobe wins
//- Strap low linear, high interleaved, static
//- Drive bus only while output enable low
//- Read data from previously addressed location
module pbs_sram #(
	parameter int DEPTH = pbs_pkg::FIFO_DEPTH
) (
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        processor_addr_strobe_n_i,
	input  wire logic        controller_addr_strobe_n_i,
	input  wire logic        burst_step_n_i,
	input  wire logic        chip_select_primary_n_i,
	input  wire logic        chip_select_second_i,
	input  wire logic        chip_select_third_n_i,
	input  wire logic [3:0]  byte_lane_write_sel_n_i,
	input  wire logic        byte_write_qualifier_n_i,
	input  wire logic        all_bytes_write_n_i,
	input  wire logic        burst_order_i,
	input  wire logic        out_enable_n_i,
	input  wire logic [31:0] dq_i,
	output logic [31:0]      dq_o,
	output logic             dq_oe_o,
	output logic             wr_ready_o
);
	import pbs_pkg::*;

	function automatic logic [1:0] burst_lo(input logic linear,
		input logic [1:0] off, input logic [1:0] cnt);
		burst_lo = linear ? 2'(off + cnt) : (off ^ cnt);
	endfunction

	logic [DATA_W-1:0] mem [WORDS];

	pbs_in_s     in_reg;
	pbs_in_s     in_next;
	logic [13:0] base_reg;
	logic [13:0] base_next;
	logic [1:0]  off_reg;
	logic [1:0]  off_next;
	logic [1:0]  cnt_reg;
	logic [1:0]  cnt_next;
	logic        active_reg;
	logic        active_next;
	logic        desel_reg;
	logic        desel_next;
	logic        drive_reg;
	logic        drive_next;
	logic [31:0] dout_reg;
	logic [31:0] dout_next;

	logic        sel;
	logic        proc_go;
	logic        ctrl_go;
	logic        strobe;
	logic        start;
	logic        desel;
	logic        step;
	logic        access;
	logic        wr_cyc;
	logic        rd;
	logic [15:0] acc_addr;
	pbs_wr_s     wr_item;
	pbs_wr_s     drain_item;
	logic        wr_accept;
	logic        drain_valid;
	logic        drain;

	always_comb begin
		in_next = '{addr: addr_i,
			proc_strobe_n: processor_addr_strobe_n_i,
			ctrl_strobe_n: controller_addr_strobe_n_i,
			burst_step_n: burst_step_n_i,
			cs_primary_n: chip_select_primary_n_i,
			cs_second: chip_select_second_i,
			cs_third_n: chip_select_third_n_i,
			lane_sel_n: byte_lane_write_sel_n_i,
			qualifier_n: byte_write_qualifier_n_i,
			all_bytes_n: all_bytes_write_n_i,
			linear_n: burst_order_i,
			wdata: dq_i};
	end

	always_comb begin
		sel     = !in_reg.cs_primary_n & in_reg.cs_second &
			!in_reg.cs_third_n;
		proc_go = !in_reg.proc_strobe_n & !in_reg.cs_primary_n;
		ctrl_go = !in_reg.ctrl_strobe_n & !proc_go;
		strobe  = proc_go | ctrl_go;
		start   = strobe & sel;
		desel   = strobe & !sel;
		step    = !strobe & active_reg & !in_reg.burst_step_n;
		access  = start | (active_reg & !strobe);

		base_next   = start ? in_reg.addr[15:2] : base_reg;
		off_next    = start ? in_reg.addr[1:0] : off_reg;
		cnt_next    = start ? CNT_RST :
			(step ? 2'(cnt_reg + CNT_STEP) : cnt_reg);
		active_next = start ? 1'b1 : (desel ? 1'b0 : active_reg);
		acc_addr    = {base_next,
			burst_lo(!in_reg.linear_n, off_next, cnt_next)};

		if (!in_reg.all_bytes_n) begin
			wr_item.be = BE_ALL;
		end else if (!in_reg.qualifier_n) begin
			wr_item.be = ~in_reg.lane_sel_n;
		end else begin
			wr_item.be = BE_NONE;
		end
		wr_item.addr = acc_addr;
		wr_item.data = in_reg.wdata;
		// A processor-strobed start is always a read
		wr_cyc = access & !proc_go & (wr_item.be != BE_NONE);
		rd     = access & !wr_cyc;

		desel_next = desel ? 1'b1 : (access ? 1'b0 : desel_reg);
		drive_next = rd & !desel_reg;
		dout_next  = rd ? mem[acc_addr] : dout_reg;
	end

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			in_reg     <= IN_RST;
			base_reg   <= BASE_RST;
			off_reg    <= CNT_RST;
			cnt_reg    <= CNT_RST;
			active_reg <= 1'b0;
			desel_reg  <= 1'b1;
			drive_reg  <= 1'b0;
			dout_reg   <= DATA_RST;
			wr_ready_o <= 1'b1;
		end else begin
			in_reg     <= in_next;
			base_reg   <= base_next;
			off_reg    <= off_next;
			cnt_reg    <= cnt_next;
			active_reg <= active_next;
			desel_reg  <= desel_next;
			drive_reg  <= drive_next;
			dout_reg   <= dout_next;
			wr_ready_o <= wr_accept;
		end
	end

	// self-timed write path; reads own the array port first
	// so a read of a word still queued sees the old contents
	pbs_fifo #(
		.WIDTH ($bits(pbs_wr_s)),
		.DEPTH (DEPTH)
	) u_wr_fifo (
		.clock_i     (clock_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (wr_cyc),
		.in_ready_o  (wr_accept),
		.in_data_i   (wr_item),
		.out_valid_o (drain_valid),
		.out_ready_i (!rd),
		.out_data_o  (drain_item)
	);

	assign drain = drain_valid & !rd;

	always_ff @(posedge clock_i) begin
		if (drain) begin
			for (int n = 0; n < LANES; n++) begin
				if (drain_item.be[n]) begin
					mem[drain_item.addr][8*n +: 8] <=
						drain_item.data[8*n +: 8];
				end
			end
		end
	end

	assign dq_oe_o = drive_reg & !out_enable_n_i;
	assign dq_o    = dout_reg;

	property p_capture;
		@(posedge clock_i) disable iff (!nrst_i)
		$past(nrst_i) |-> in_reg == $past(in_next);
	endproperty
	a_capture: assert property (p_capture)
		else $error("input register missed a pin value");

	property p_read_pipe;
		@(posedge clock_i) disable iff (!nrst_i)
		rd & !desel_reg & !out_enable_n_i ##1 !out_enable_n_i
			|-> dq_oe_o && dq_o == $past(dout_next);
	endproperty
	a_read_pipe: assert property (p_read_pipe)
		else $error("read data not launched one edge later");

	property p_addr_load;
		@(posedge clock_i) disable iff (!nrst_i)
		start |=> base_reg == $past(in_reg.addr[15:2]) &&
			off_reg == $past(in_reg.addr[1:0]) && cnt_reg == CNT_RST;
	endproperty
	a_addr_load: assert property (p_addr_load)
		else $error("address not loaded on selected strobe");

	property p_step;
		@(posedge clock_i) disable iff (!nrst_i)
		step |=> cnt_reg == 2'($past(cnt_reg) + 2'h1);
	endproperty
	a_step: assert property (p_step)
		else $error("burst counter did not step");

	property p_hold;
		@(posedge clock_i) disable iff (!nrst_i)
		!strobe & in_reg.burst_step_n |=> $stable(cnt_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("burst counter moved without advance");

	property p_ignore_proc;
		@(posedge clock_i) disable iff (!nrst_i)
		in_reg.cs_primary_n & in_reg.ctrl_strobe_n
			|=> active_reg == $past(active_reg);
	endproperty
	a_ignore_proc: assert property (p_ignore_proc)
		else $error("processor strobe honoured with primary high");

	property p_byte_wr;
		@(posedge clock_i) disable iff (!nrst_i)
		wr_cyc & in_reg.all_bytes_n
			|-> !in_reg.qualifier_n && wr_item.be == ~in_reg.lane_sel_n;
	endproperty
	a_byte_wr: assert property (p_byte_wr)
		else $error("byte write lanes wrong");

	property p_all_wr;
		@(posedge clock_i) disable iff (!nrst_i)
		access & !proc_go & !in_reg.all_bytes_n |-> wr_cyc &&
			wr_item.be == BE_ALL;
	endproperty
	a_all_wr: assert property (p_all_wr)
		else $error("all-bytes write did not cover the word");

	property p_mask;
		@(posedge clock_i) disable iff (!nrst_i)
		rd & desel_reg |=> !dq_oe_o;
	endproperty
	a_mask: assert property (p_mask)
		else $error("output driven on first read after deselect");

	property p_oe;
		@(posedge clock_i) disable iff (!nrst_i)
		out_enable_n_i |-> !dq_oe_o;
	endproperty
	a_oe: assert property (p_oe)
		else $error("bus driven with output enable high");

	property p_prio;
		@(posedge clock_i) disable iff (!nrst_i)
		proc_go & !in_reg.ctrl_strobe_n & sel |-> rd && !wr_cyc;
	endproperty
	a_prio: assert property (p_prio)
		else $error("controller strobe won over processor strobe");

	property p_order;
		@(posedge clock_i) disable iff (!nrst_i)
		access |-> acc_addr[1:0] == (in_reg.linear_n ?
			(off_next ^ cnt_next) : 2'(off_next + cnt_next));
	endproperty
	a_order: assert property (p_order)
		else $error("burst address order wrong");
endmodule
